// file: design/atten_ctrl_pkg.sv
// Constants and carrier types shared by the step attenuator controller.
// Assumes a 200 MHz core clock and a link clock slower than half of it.
package atten_ctrl_pkg;

    // Width of the serial attenuation word.
    localparam int WORD_BITS = 8;
    // Number of binary-weighted parallel control lines.
    localparam int WEIGHT_BITS = 5;
    // Position of the lowest weight inside the serial word.
    localparam int WEIGHT_LSB = 1;
    // Serial word value that selects maximum attenuation (15.5 dB times 4).
    localparam logic [7:0] MAX_ATTEN_WORD = 8'h3E;
    // Core clock period in picoseconds.
    localparam int CORE_PERIOD_PS = 5000;
    // Least spacing between two attenuation changes, in nanoseconds (25 kHz).
    localparam int MIN_CHANGE_NS = 40000;
    // Same spacing in core cycles, rounded up.
    localparam int MIN_CHANGE_CYC = (MIN_CHANGE_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    // Strobe high time and line settle time, in nanoseconds.
    localparam int SETTLE_NS = 100;
    // Settle time in core cycles, rounded up.
    localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    // Reset value of the parallel lines.
    localparam logic [4:0] WEIGHTS_RESET = 5'h00;

    // Programming mode requested by the user.
    typedef enum logic [1:0] {
        MODE_DIRECT  = 2'h0,
        MODE_LATCHED = 2'h1,
        MODE_SERIAL  = 2'h2
    } mode_t;

    // One user request: mode and five-bit attenuation code in half-dB steps.
    typedef struct packed {
        mode_t      mode;
        logic [4:0] code;
    } request_t;

    // Pins driven towards the attenuator.
    typedef struct packed {
        logic       serialSelect;
        logic       transferStrobe;
        logic       serialData;
        logic [4:0] parallelWeightInputs;
    } pins_t;

endpackage

// file: design/atten_ctrl.sv
// Controller that drives a 5-bit step attenuator through its control pins.
// Assumes linkClk is a free-running clock of at most 10 MHz for the serial shift clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Latched: strobe low, change lines, pulse strobe.
// - Direct: hold strobe high, lines apply at once.
// - Shift whole word with strobe low, then pulse.
// - Serial word is attenuation in dB times four.
// - Word bits zero, six and seven sent low.
// - Parallel lines held low in serial mode.
// - After parallel power-up, lines low, load word.
// - Mode sequencing needed only once after power-up.
// - Never change attenuation faster than 25 kHz.
// - Latched: strobe low before next parallel word.
module atten_ctrl (
    // Core clock and reset.
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    // Link clock that paces serial shifting.
    input  wire logic                     linkClk,
    // User request port.
    input  wire logic                     reqValid,
    input  wire atten_ctrl_pkg::request_t reqData,
    output logic                          reqReady,
    // Pins towards the attenuator.
    output atten_ctrl_pkg::pins_t         pins,
    output logic                          serialClk
);

    // Core-side sequencer states.
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_SETUP  = 7'b0000010,
        ST_SHIFT  = 7'b0000100,
        ST_STRHI  = 7'b0001000,
        ST_STRLO  = 7'b0010000,
        ST_GAP    = 7'b0100000,
        ST_DIRECT = 7'b1000000
    } state_t;

    state_t                 stateReg;     // Sequencer state.
    atten_ctrl_pkg::request_t reqReg;     // Captured request.
    logic [15:0]            timerReg;     // Settle and rate timer.
    logic                   firstSerialDoneReg; // Power-up sequencing done.
    logic [7:0]             wordReg;      // Serial word handed to the link side.
    logic                   goToggleReg;  // Core toggles to start a shift.
    logic [2:0]             doneSyncReg;  // Link done toggle into core domain.
    logic [1:0]             goSyncReg;    // Core start toggle into link domain.
    logic                   goSeenReg;    // Link side copy of last start toggle.
    logic                   doneToggleReg; // Link toggles when a word is shifted.
    logic [3:0]             bitCntReg;    // Bits still to shift.
    logic [7:0]             shiftReg;     // Link-side shift copy.
    logic                   shiftActiveReg; // Link is clocking bits out.
    logic                   gateReg;      // Enables the outgoing shift clock.
    logic                   dataReg;      // Serial data bit on the pin.
    logic                   shiftDone;    // One-cycle pulse in core domain.
    logic                   selectReg;    // Serial select pin.
    logic                   strobeReg;    // Transfer strobe pin.
    logic [4:0]             weightsReg;   // Parallel weight pins.
    logic [1:0]             linkRstSyncReg; // Reset release retimed to the link clock.
    logic                   linkRstn;     // Link-domain reset, active low.

    // The port stays closed until the power-up serial load has been latched.
    assign reqReady  = (stateReg == ST_IDLE) && firstSerialDoneReg;
    assign shiftDone = doneSyncReg[2] ^ doneSyncReg[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: one attenuation change per request, paced by the rate timer.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            // Reset starts a serial load of the maximum word, so the device has
            // a word with a low top bit before any parallel request can arrive.
            stateReg <= ST_SETUP;
            reqReg   <= '{mode: atten_ctrl_pkg::MODE_SERIAL,
                          code: atten_ctrl_pkg::MAX_ATTEN_WORD[5:1]};
            timerReg <= 16'(atten_ctrl_pkg::SETTLE_CYC);
        end else begin
            if (timerReg != 16'h0000) begin
                timerReg <= timerReg - 16'h0001;
            end
            case (stateReg)
                ST_IDLE: begin
                    if (reqValid) begin
                        reqReg   <= reqData;
                        timerReg <= 16'(atten_ctrl_pkg::SETTLE_CYC);
                        stateReg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Lines and select settle before a latched strobe pulse or a shift; direct mode raises the strobe with the lines.
                    if (timerReg == 16'h0000) begin
                        if (reqReg.mode == atten_ctrl_pkg::MODE_SERIAL) begin
                            stateReg <= ST_SHIFT;
                        end else if (reqReg.mode == atten_ctrl_pkg::MODE_LATCHED) begin
                            timerReg <= 16'(atten_ctrl_pkg::SETTLE_CYC);
                            stateReg <= ST_STRHI;
                        end else begin
                            stateReg <= ST_DIRECT;
                        end
                    end
                end
                ST_SHIFT: begin
                    // Strobe stays low until every bit has left.
                    if (shiftDone) begin
                        timerReg <= 16'(atten_ctrl_pkg::SETTLE_CYC);
                        stateReg <= ST_STRHI;
                    end
                end
                ST_STRHI: begin
                    if (timerReg == 16'h0000) begin
                        timerReg <= 16'(atten_ctrl_pkg::SETTLE_CYC);
                        stateReg <= ST_STRLO;
                    end
                end
                ST_STRLO: begin
                    // Strobe back low before the next word is presented.
                    if (timerReg == 16'h0000) begin
                        timerReg <= 16'(atten_ctrl_pkg::MIN_CHANGE_CYC);
                        stateReg <= ST_GAP;
                    end
                end
                ST_DIRECT: begin
                    timerReg <= 16'(atten_ctrl_pkg::MIN_CHANGE_CYC);
                    stateReg <= ST_GAP;
                end
                ST_GAP: begin
                    // Rate limit: at most one change per 40 us.
                    if (timerReg == 16'h0000) begin
                        stateReg <= ST_IDLE;
                    end
                end
                default: begin
                    stateReg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up sequencing flag: set once a serial word with a low top bit is latched.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            firstSerialDoneReg <= 1'b0;
        end else if (stateReg == ST_STRLO && reqReg.mode == atten_ctrl_pkg::MODE_SERIAL) begin
            firstSerialDoneReg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive. Select powers up serial with the weight lines low, and the
    // power-up serial load runs before the request port first opens.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            selectReg  <= 1'b1;
            strobeReg  <= 1'b0;
            weightsReg <= atten_ctrl_pkg::WEIGHTS_RESET;
        end else begin
            if (stateReg == ST_SETUP) begin
                // Select low for parallel, high for serial.
                selectReg <= (reqReg.mode == atten_ctrl_pkg::MODE_SERIAL);
                if (reqReg.mode == atten_ctrl_pkg::MODE_SERIAL) begin
                    weightsReg <= 5'h00;
                end else begin
                    weightsReg <= reqReg.code;
                end
                // Direct mode keeps the strobe high; others hold it low.
                strobeReg <= (reqReg.mode == atten_ctrl_pkg::MODE_DIRECT);
            end else if (stateReg == ST_STRHI && timerReg == 16'h0000) begin
                strobeReg <= 1'b1;
            end else if (stateReg == ST_STRLO && timerReg == 16'h0000) begin
                strobeReg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Word hand-off toward the link domain; the word is stable before the toggle.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wordReg     <= atten_ctrl_pkg::MAX_ATTEN_WORD;
            goToggleReg <= 1'b0;
            doneSyncReg <= 3'h0;
        end else begin
            doneSyncReg <= {doneSyncReg[1:0], doneToggleReg};
            if (stateReg == ST_SETUP && timerReg == 16'h0000 &&
                reqReg.mode == atten_ctrl_pkg::MODE_SERIAL) begin
                goToggleReg <= ~goToggleReg;
            end
            if (stateReg == ST_IDLE && reqValid) begin
                // Code sits in bits one to five; bits zero, six and seven stay low.
                wordReg <= {2'b00, reqData.code, 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release retimed to the link clock, so no link flop leaves reset
    // at a random point of its period.
    always_ff @(negedge linkClk or negedge rstn) begin
        if (!rstn) begin
            linkRstSyncReg <= 2'h0;
        end else begin
            linkRstSyncReg <= {linkRstSyncReg[0], 1'b1};
        end
    end

    assign linkRstn = linkRstSyncReg[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: data changes on the falling edge, device samples on the rise.
    always_ff @(negedge linkClk or negedge linkRstn) begin
        if (!linkRstn) begin
            goSyncReg      <= 2'h0;
            goSeenReg      <= 1'b0;
            doneToggleReg  <= 1'b0;
            bitCntReg      <= 4'h0;
            shiftReg       <= 8'h00;
            shiftActiveReg <= 1'b0;
            gateReg        <= 1'b0;
            dataReg        <= 1'b0;
        end else begin
            goSyncReg <= {goSyncReg[0], goToggleReg};
            gateReg   <= 1'b0;
            if (!shiftActiveReg && (goSyncReg[1] != goSeenReg)) begin
                goSeenReg      <= goSyncReg[1];
                shiftReg       <= wordReg;
                bitCntReg      <= 4'(atten_ctrl_pkg::WORD_BITS);
                shiftActiveReg <= 1'b1;
            end else if (shiftActiveReg) begin
                if (bitCntReg != 4'h0) begin
                    // Least significant bit goes out first.
                    dataReg   <= shiftReg[0];
                    shiftReg  <= {1'b0, shiftReg[7:1]};
                    bitCntReg <= bitCntReg - 4'h1;
                    gateReg   <= 1'b1;
                end else begin
                    shiftActiveReg <= 1'b0;
                    doneToggleReg  <= ~doneToggleReg;
                end
            end
        end
    end

    // Shift clock is high only in the high phase of a gated period.
    assign serialClk       = gateReg & linkClk;
    // All pins leave through one assignment, so each bit has a single driver.
    assign pins = '{serialSelect: selectReg, transferStrobe: strobeReg,
                    serialData: dataReg, parallelWeightInputs: weightsReg};

endmodule

// file: dv/atten_ctrl_monitor.sv
// Checker for the attenuator controller, watching only its top-level ports.
// Assumes one core clock domain; serialClk is sampled as a plain signal.
`timescale 1ns/1ps

module atten_ctrl_monitor (
    // Clock and reset.
    input wire logic                     core_clk,
    input wire logic                     rstn,
    // Link clock and user side.
    input wire logic                     linkClk,
    input wire logic                     reqValid,
    input wire atten_ctrl_pkg::request_t reqData,
    input wire logic                     reqReady,
    // Pins towards the attenuator.
    input wire atten_ctrl_pkg::pins_t    pins,
    input wire logic                     serialClk
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic        taken;   // A request is accepted at this edge.
    logic [15:0] busyCnt; // Cycles spent with the request port closed.
    assign taken = reqValid && reqReady;

    ////////////////////////////////////////////////////////////////////////////////
    // Busy counter, so the pacing gap can be checked without a huge repetition.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busyCnt <= 16'h0000;
        end else begin
            busyCnt <= reqReady ? 16'h0000 : busyCnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_ready_closes: assert property (taken |=> !reqReady)
        else $error("request port stayed open after a take");
    a_rate_gap: assert property ($rose(reqReady) |-> busyCnt >= 16'(atten_ctrl_pkg::MIN_CHANGE_CYC))
        else $error("attenuation changes spaced closer than the limit");
    a_serial_lines: assert property (pins.serialSelect |-> pins.parallelWeightInputs == 5'h00)
        else $error("weight lines not low in serial mode");
    a_strobe_shift: assert property (serialClk |-> !pins.transferStrobe)
        else $error("strobe high while shifting");
    a_strobe_width: assert property ($rose(pins.transferStrobe) |-> pins.transferStrobe[*8])
        else $error("strobe pulse too short");
    a_direct_apply: assert property (taken && reqData.mode == atten_ctrl_pkg::MODE_DIRECT
        |-> ##2 (pins.transferStrobe && !pins.serialSelect
        && pins.parallelWeightInputs == $past(reqData.code, 2)))
        else $error("direct request not applied with strobe high");
    a_latched_setup: assert property (taken && reqData.mode == atten_ctrl_pkg::MODE_LATCHED
        |-> ##2 (!pins.transferStrobe && !pins.serialSelect
        && pins.parallelWeightInputs == $past(reqData.code, 2)))
        else $error("latched request lines not set with strobe low");
    a_serial_select: assert property (taken && reqData.mode == atten_ctrl_pkg::MODE_SERIAL
        |-> ##2 (pins.serialSelect && !pins.transferStrobe))
        else $error("serial request did not select serial mode");
endmodule

bind atten_ctrl atten_ctrl_monitor mon (.core_clk(core_clk), .rstn(rstn), .linkClk(linkClk),
    .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady), .pins(pins),
    .serialClk(serialClk));

// file: dv/atten_device_model.sv
// Behavioural model of the attenuator's control logic, fed by the controller pins.
// Assumes power-up at time zero; it has no reset pin, like the real part.
`timescale 1ns/1ps

module atten_device_model (
    // Control pins from the controller.
    input  wire logic       serialSelect,
    input  wire logic       transferStrobe,
    input  wire logic       serialData,
    input  wire logic       serialClk,
    input  wire logic [4:0] weights,
    // Observed state.
    output logic [4:0]      coreState,
    output logic [7:0]      serialWord
);
    logic [7:0] shiftReg;            // Eight shift stages, first stage is bit 7.
    logic [4:0] parWord = 5'h1F;     // Parallel latch, maximum at power-up.
    initial serialWord = 8'h3E;      // Serial latch, maximum at power-up.

    // Every clock rise shifts, whatever the strobe does; LSB arrives first.
    always @(posedge serialClk) shiftReg <= {serialData, shiftReg[7:1]};
    // Strobe rise in serial mode transfers the whole word to the core.
    always @(posedge transferStrobe) if (serialSelect) serialWord <= shiftReg;
    // Parallel latch is open while the strobe is high, so direct mode follows the lines.
    always @* if (transferStrobe && !serialSelect) parWord = weights;
    // Select chooses the source at once; weights are binary in half-dB steps.
    assign coreState = serialSelect ? serialWord[5:1] : parWord;
endmodule

// file: dv/atten_ctrl_tb.sv
// Self-checking bench: user requests in every mode, result read from the device model.
// Assumes the controller paces itself, so each request waits for reqReady.
`timescale 1ns/1ps

module atten_ctrl_tb;
    logic                     core_clk;
    logic                     rstn;
    logic                     linkClk;
    logic                     reqValid;
    atten_ctrl_pkg::request_t reqData;
    logic                     reqReady;
    atten_ctrl_pkg::pins_t    pins;
    logic                     serialClk;
    logic [4:0]               coreState;
    logic [7:0]               serialWord;
    int                       error_cnt;
    int                       checks;

    atten_ctrl uut (.core_clk(core_clk), .rstn(rstn), .linkClk(linkClk), .reqValid(reqValid),
        .reqData(reqData), .reqReady(reqReady), .pins(pins), .serialClk(serialClk));
    atten_device_model dev (.serialSelect(pins.serialSelect),
        .transferStrobe(pins.transferStrobe), .serialData(pins.serialData),
        .serialClk(serialClk), .weights(pins.parallelWeightInputs),
        .coreState(coreState), .serialWord(serialWord));

    ////////////////////////////////////////////////////////////////////////////////
    // Clocks: the link clock has its own odd phase so the crossing is exercised.
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        linkClk = 1'b0;
        #37.3;
        forever #62.5 linkClk = ~linkClk;
    end

    // Prints the verdict; the single end point of the run.
    task automatic conclude();
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Offers one request, holds it until taken, then waits out the pacing gap.
    task automatic send(input atten_ctrl_pkg::mode_t m, input logic [4:0] c);
        int n;
        n = 0;
        reqValid <= 1'b1;
        reqData  <= '{mode: m, code: c};
        // The first request also waits out the power-up serial load.
        do begin
            @(posedge core_clk);
            n++;
        end while (reqReady !== 1'b1 && n < 20000);
        reqValid <= 1'b0;
        if (reqReady !== 1'b1) check(8'h00, 8'h01, "request never taken");
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (reqReady !== 1'b1 && n < 20000);
        if (reqReady !== 1'b1) check(8'h00, 8'h01, "ready never returned");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: every mode, boundary codes, and mode changes in both directions.
    atten_ctrl_pkg::mode_t modes [7];
    logic [4:0]            codes [7];
    initial begin
        modes = '{atten_ctrl_pkg::MODE_SERIAL, atten_ctrl_pkg::MODE_LATCHED,
            atten_ctrl_pkg::MODE_DIRECT, atten_ctrl_pkg::MODE_DIRECT,
            atten_ctrl_pkg::MODE_SERIAL, atten_ctrl_pkg::MODE_SERIAL,
            atten_ctrl_pkg::MODE_LATCHED};
        codes = '{5'h19, 5'h0A, 5'h15, 5'h00, 5'h1F, 5'h01, 5'h1F};
        error_cnt = 0;
        checks    = 0;
        rstn      = 1'b0;
        reqValid  = 1'b0;
        reqData   = '0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        check({7'h00, pins.serialSelect}, 8'h01, "select after reset");
        check({3'h0, pins.parallelWeightInputs}, 8'h00, "lines after reset");
        check({3'h0, coreState}, 8'h1F, "power-up state");
        foreach (modes[i]) begin
            send(modes[i], codes[i]);
            check({3'h0, coreState}, {3'h0, codes[i]}, "core state");
            if (modes[i] == atten_ctrl_pkg::MODE_SERIAL)
                check(serialWord, {2'b00, codes[i], 1'b0}, "serial word");
        end
        conclude();
    end

    // Watchdog: seven paced requests take well under this span.
    initial begin
        #450000;
        error_cnt++;
        conclude();
    end
endmodule
